//--- src/pvc_pkg.sv
// Purpose: constants for the oscillator tuning and calibration enable block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   trim code lives at its own offset, reached through the same port
package pvc_pkg;
  localparam logic [7:0] ADDR_TRIM       = 8'h59;
  localparam logic [7:0] ADDR_PLL_RESET  = 8'h5c;
  localparam logic [7:0] ADDR_TUNE_CTRL  = 8'h5d;
  localparam logic [7:0] ADDR_TUNE_STAT  = 8'h5e;
  localparam logic [7:0] ADDR_CAL_EN     = 8'h61;
  localparam logic [7:0] RST_PLL_RESET   = 8'h00;
  localparam logic [7:0] RST_TUNE_CTRL   = 8'h40;
  localparam logic [7:0] RST_CAL_EN      = 8'h01;
  localparam logic [6:0] RST_TRIM        = 7'h00;
  localparam logic [6:0] TRIM_MID        = 7'h40;
  localparam int         BIT_ENABLE      = 0;
  localparam int         STL_LSB         = 4;
  localparam int         STL_MSB         = 6;
  localparam int         TRIM_MSB        = 6;
  localparam int         TRIM_STEPS      = 7;
  // settle base time in ns; wait is base shifted left by the settle field
  localparam int         SETTLE_BASE_NS  = 80;
  localparam int         CLK_PERIOD_NS   = 10;
  localparam int         SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_DECIDE = 2'b11,
    ST_DONE   = 2'b10
  } pvc_state_type;
endpackage : pvc_pkg

//--- src/pvc_settle_timer.sv
// Purpose: settle wait counter for the tuning engine
// Assumes: load pulses restart the count
// Notes:   length is base cycles times two to the settle field
module pvc_settle_timer #(
  parameter int BASE_CYC = pvc_pkg::SETTLE_BASE_CYC
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       load_i,
  input  wire logic [2:0] stl_i,
  output logic            expired_o
);
  typedef struct packed {
    logic [15:0] count;
    logic        busy;
  } pvc_timer_type;
  pvc_timer_type st;
  pvc_timer_type next_st;

  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.count = 16'(BASE_CYC << stl_i);
      next_st.busy  = 1'b1;
    end else if (st.busy) begin
      if (st.count <= 16'h0001) begin
        next_st.busy = 1'b0;
      end
      next_st.count = st.count - 16'h0001;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expired_o = st.busy && (st.count <= 16'h0001);
endmodule : pvc_settle_timer

//--- src/pvc_top.sv
// Behaviour
// - tuning starts when tuning reset falls
// - engine centres trim code by comparison
// - settle field sets wait, larger longer
// - complete reads one when done or skipped
// - calibration enable runs or holds calibration
// - clearing enable resets digital and link dividers
//
// Purpose: oscillator tuning engine and converter calibration enable
// Assumes: register port is synchronous, one access per cycle
// Notes:   VCO_FAST_I says the oscillator is above target for the current trim
module pvc_top (
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       VCO_FAST_I,
  output logic      [6:0] OSC_TRIM_O,
  output logic            PLL_RESET_O,
  output logic            CAL_RUN_O,
  output logic            CAL_RESET_O,
  output logic            DIV_RESET_O
);
  typedef struct packed {
    logic                  pll_reset;
    logic [7:0]            tune_ctrl;
    logic                  cal_en;
    logic [6:0]            trim;
    logic [6:0]            probe;
    logic [2:0]            step;
    logic                  complete;
    pvc_pkg::pvc_state_type state;
    logic                  load;
    logic [7:0]            rdata;
  } pvc_regs_type;
  pvc_regs_type st;
  pvc_regs_type next_st;
  logic         expired;
  logic         tune_en;
  logic         wr_reset, wr_ctrl, wr_cal, wr_trim;

  assign tune_en  = st.tune_ctrl[pvc_pkg::BIT_ENABLE];
  assign wr_reset = REG_WR_I && (REG_ADDR_I == pvc_pkg::ADDR_PLL_RESET);
  assign wr_ctrl  = REG_WR_I && (REG_ADDR_I == pvc_pkg::ADDR_TUNE_CTRL);
  assign wr_cal   = REG_WR_I && (REG_ADDR_I == pvc_pkg::ADDR_CAL_EN);
  assign wr_trim  = REG_WR_I && (REG_ADDR_I == pvc_pkg::ADDR_TRIM);

  pvc_settle_timer #(
    .BASE_CYC (pvc_pkg::SETTLE_BASE_CYC)
  ) u_timer (
    .SYS_CLK_I (SYS_CLK_I),
    .RST_I     (RST_I),
    .load_i    (st.load),
    .stl_i     (st.tune_ctrl[pvc_pkg::STL_MSB:pvc_pkg::STL_LSB]),
    .expired_o (expired)
  );

  always_comb begin
    next_st      = st;
    next_st.load = 1'b0;
    // tune control stores the full byte, the others only their used bits; zero in reserved bits is left to software
    if (wr_ctrl) begin
      next_st.tune_ctrl = REG_WDATA_I;
    end
    if (wr_cal) begin
      next_st.cal_en = REG_WDATA_I[pvc_pkg::BIT_ENABLE];
    end
    // trim writes ignored mid-sequence to protect the search
    if (wr_trim && st.state != pvc_pkg::ST_SETTLE && st.state != pvc_pkg::ST_DECIDE) begin
      next_st.trim = REG_WDATA_I[pvc_pkg::TRIM_MSB:0];
    end
    if (wr_reset) begin
      next_st.pll_reset = REG_WDATA_I[pvc_pkg::BIT_ENABLE];
    end
    case (st.state)
      pvc_pkg::ST_IDLE: begin
        // falling edge of tuning reset starts or skips the sequence
        if (st.pll_reset && wr_reset && !REG_WDATA_I[pvc_pkg::BIT_ENABLE]) begin
          if (tune_en) begin
            next_st.state    = pvc_pkg::ST_SETTLE;
            next_st.complete = 1'b0;
            next_st.probe    = pvc_pkg::TRIM_MID;
            next_st.trim     = pvc_pkg::TRIM_MID;
            next_st.step     = 3'(pvc_pkg::TRIM_STEPS - 1);
            next_st.load     = 1'b1;
          end else begin
            next_st.state    = pvc_pkg::ST_DONE;
            next_st.complete = 1'b1;
          end
        end else if (wr_reset && REG_WDATA_I[pvc_pkg::BIT_ENABLE]) begin
          next_st.complete = 1'b0;
        end
      end
      pvc_pkg::ST_SETTLE: begin
        // load lands a cycle late; a stale count must not cut a fresh wait
        if (expired && !st.load) begin
          next_st.state = pvc_pkg::ST_DECIDE;
        end
      end
      pvc_pkg::ST_DECIDE: begin
        // binary search, one bit per settle period, msb first
        if (VCO_FAST_I) begin
          next_st.probe[st.step] = 1'b0;
        end
        if (st.step == 3'h0) begin
          next_st.trim     = VCO_FAST_I ? {st.probe[6:1], 1'b0} : st.probe;
          next_st.state    = pvc_pkg::ST_DONE;
          next_st.complete = 1'b1;
        end else begin
          next_st.probe[st.step - 3'h1] = 1'b1;
          next_st.trim                  = next_st.probe;
          next_st.step                  = st.step - 3'h1;
          next_st.load                  = 1'b1;
          next_st.state                 = pvc_pkg::ST_SETTLE;
        end
      end
      pvc_pkg::ST_DONE: begin
        // raising tuning reset again arms a new sequence
        if (wr_reset && REG_WDATA_I[pvc_pkg::BIT_ENABLE]) begin
          next_st.state    = pvc_pkg::ST_IDLE;
          next_st.complete = 1'b0;
        end
      end
      default: begin
        next_st.state = pvc_pkg::ST_IDLE;
      end
    endcase
    // tuning reset held high aborts any run
    if (st.pll_reset && st.state != pvc_pkg::ST_IDLE) begin
      next_st.state = pvc_pkg::ST_IDLE;
    end
    next_st.rdata = 8'h00;
    if (REG_RD_I) begin
      if (REG_ADDR_I == pvc_pkg::ADDR_PLL_RESET) begin
        next_st.rdata = {7'h00, st.pll_reset};
      end else if (REG_ADDR_I == pvc_pkg::ADDR_TUNE_CTRL) begin
        next_st.rdata = st.tune_ctrl;
      end else if (REG_ADDR_I == pvc_pkg::ADDR_TUNE_STAT) begin
        next_st.rdata = {7'h00, st.complete};
      end else if (REG_ADDR_I == pvc_pkg::ADDR_CAL_EN) begin
        next_st.rdata = {7'h00, st.cal_en};
      end else if (REG_ADDR_I == pvc_pkg::ADDR_TRIM) begin
        next_st.rdata = {1'b0, st.trim};
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st.pll_reset <= pvc_pkg::RST_PLL_RESET[0];
      st.tune_ctrl <= pvc_pkg::RST_TUNE_CTRL;
      st.cal_en    <= pvc_pkg::RST_CAL_EN[0];
      st.trim      <= pvc_pkg::RST_TRIM;
      st.probe     <= pvc_pkg::RST_TRIM;
      st.step      <= 3'h0;
      st.complete  <= 1'b0;
      st.state     <= pvc_pkg::ST_IDLE;
      st.load      <= 1'b0;
      st.rdata     <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA_O = st.rdata;
  assign OSC_TRIM_O  = st.trim;
  assign PLL_RESET_O = st.pll_reset;
  // link enable ordering against these is software's duty
  assign CAL_RUN_O   = st.cal_en;
  assign CAL_RESET_O = !st.cal_en;
  assign DIV_RESET_O = !st.cal_en;

  // a tuning reset abort cancels the timing checks of the run it kills
  a_start_on_release: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_IDLE && st.pll_reset && wr_reset
      && !REG_WDATA_I[pvc_pkg::BIT_ENABLE] && tune_en)
      |=> (st.state == pvc_pkg::ST_SETTLE && !st.complete))
    else $error("tuning did not start on reset release");
  a_mid_start: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_IDLE && st.pll_reset && wr_reset
      && !REG_WDATA_I[pvc_pkg::BIT_ENABLE] && tune_en) |=> (OSC_TRIM_O == pvc_pkg::TRIM_MID))
    else $error("search did not start from mid trim");
  a_skip_done: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_IDLE && st.pll_reset && wr_reset
      && !REG_WDATA_I[pvc_pkg::BIT_ENABLE] && !tune_en) |=> st.complete)
    else $error("skipped tuning not reported complete");
  a_busy_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_SETTLE || st.state == pvc_pkg::ST_DECIDE) |-> !st.complete)
    else $error("complete high while tuning");
  a_done_flag: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_DONE) |-> st.complete)
    else $error("complete low after tuning finished");
  a_settle_wait: assert property (@(posedge SYS_CLK_I) disable iff (RST_I || st.pll_reset)
    $rose(st.state == pvc_pkg::ST_SETTLE) |=> (st.state == pvc_pkg::ST_SETTLE)[*8])
    else $error("settle wait too short");
  a_settle_end: assert property (@(posedge SYS_CLK_I) disable iff (RST_I || st.pll_reset)
    ($rose(st.state == pvc_pkg::ST_SETTLE)
      && st.tune_ctrl[pvc_pkg::STL_MSB:pvc_pkg::STL_LSB] == 3'h0)
      |=> (st.state == pvc_pkg::ST_SETTLE)[*8] ##1 (st.state == pvc_pkg::ST_DECIDE))
    else $error("settle wait wrong at field zero");
  a_abort_run: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.pll_reset && (st.state == pvc_pkg::ST_SETTLE || st.state == pvc_pkg::ST_DECIDE))
      |=> (st.state == pvc_pkg::ST_IDLE))
    else $error("tuning reset did not abort the run");
  a_div_reset: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (wr_cal && !REG_WDATA_I[pvc_pkg::BIT_ENABLE]) |=> (DIV_RESET_O && CAL_RESET_O && !CAL_RUN_O))
    else $error("dividers not reset on enable clear");
  a_trim_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (st.state == pvc_pkg::ST_SETTLE && !st.pll_reset) |=> $stable(st.trim))
    else $error("trim moved during settle");
endmodule : pvc_top

//--- dv/pvc_tb_top.sv
// Purpose: register-level bench for the tuning engine and calibration enable
// Assumes: settle field is 0 or 1 whenever a tuning run starts, so runs stay short
// Notes:   oscillator modelled as fast whenever trim is above a fixed target
module pvc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] TARGET = 7'h2b;
  logic       clk       = 1'b0;
  logic       rst       = 1'b1;
  logic       wr        = 1'b0;
  logic       rd        = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] rdata;
  logic [6:0] trim;
  logic       pll_rst;
  logic       cal_run;
  logic       cal_rst;
  logic       div_rst;
  int         fails     = 0;
  int         cmp_count = 0;
  int         t0;
  int         t1;

  initial forever #5 clk = ~clk;

  pvc_top dut_u (
    .SYS_CLK_I  (clk),
    .RST_I      (rst),
    .REG_WR_I   (wr),
    .REG_RD_I   (rd),
    .REG_ADDR_I (addr),
    .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata),
    .VCO_FAST_I (trim > TARGET),
    .OSC_TRIM_O (trim),
    .PLL_RESET_O(pll_rst),
    .CAL_RUN_O  (cal_run),
    .CAL_RESET_O(cal_rst),
    .DIV_RESET_O(div_rst)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 wr = 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_chk

  // bounded poll of the complete flag; each poll spans two cycles
  task automatic poll(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 rd = 1'b1;
      addr = 8'h5e;
      @(posedge clk);
      #1 rd = 1'b0;
      n++;
    end while (rdata[0] !== 1'b1 && n < 400);
    chk({7'h0, rdata[0]}, 8'h01);
  endtask : poll

  task automatic tune(input logic [2:0] stl, input logic en);
    wr_reg(8'h5c, 8'h01);
    wr_reg(8'h5d, {1'b0, stl, 3'b000, en});
    wr_reg(8'h5c, 8'h00);
  endtask : tune

  task automatic stop_test;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(8'h5c, 8'h00);
    rd_chk(8'h5d, 8'h40);
    rd_chk(8'h5e, 8'h00);
    rd_chk(8'h61, 8'h01);
    rd_chk(8'h59, 8'h00);
    rd_chk(8'h33, 8'h00);
    chk({5'h0, cal_run, cal_rst, div_rst}, 8'h04);
    tune(3'h0, 1'b0);
    rd_chk(8'h5e, 8'h01);
    wr_reg(8'h5c, 8'h01);
    chk({7'h0, pll_rst}, 8'h01);
    wr_reg(8'h5d, 8'h01);
    wr_reg(8'h5c, 8'h00);
    chk({1'b0, trim}, 8'h40);
    // trim write mid-run must be ignored, not derail the search
    wr_reg(8'h59, 8'h7f);
    rd_chk(8'h5e, 8'h00);
    poll(t0);
    chk({1'b0, trim}, {1'b0, TARGET});
    rd_chk(8'h59, {1'b0, TARGET});
    tune(3'h1, 1'b1);
    poll(t1);
    chk({7'h0, t1 > t0 + 20}, 8'h01);
    tune(3'h0, 1'b1);
    wr_reg(8'h5c, 8'h01);
    rd_chk(8'h5e, 8'h00);
    wr_reg(8'h5c, 8'h00);
    poll(t0);
    wr_reg(8'h59, 8'h15);
    rd_chk(8'h59, 8'h15);
    chk({1'b0, trim}, 8'h15);
    wr_reg(8'h61, 8'h00);
    chk({5'h0, cal_run, cal_rst, div_rst}, 8'h03);
    rd_chk(8'h61, 8'h00);
    wr_reg(8'h61, 8'hff);
    rd_chk(8'h61, 8'h01);
    chk({5'h0, cal_run, cal_rst, div_rst}, 8'h04);
    wr_reg(8'h5c, 8'h01);
    wr_reg(8'h5d, 8'h70);
    rd_chk(8'h5d, 8'h70);
    wr_reg(8'h5d, 8'h01);
    wr_reg(8'h5c, 8'h00);
    // reset in mid-run must drop everything back to defaults
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(8'h5e, 8'h00);
    rd_chk(8'h5d, 8'h40);
    chk({1'b0, trim}, 8'h00);
    stop_test();
  end

  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule : pvc_tb_top
